// ==== sac_pkg.sv ====
// package with register map, field layout and timing constants for the converter control
//
// Summary of operation
// RULE1: control write restarts conversion, abandoning current one
// RULE2: conversion takes 16 to 17 converter clocks
// RULE3: eight-bit result, one mux of eight channels
// RULE4: finish loads result, then flag or interrupt
// RULE5: continuous mode overwrites result every conversion
// RULE6: continuous mode restarts until bit cleared
// RULE7: flag set at end, cleared by result read
// RULE8: single mode: one conversion per control write
// RULE9: software discards result of interrupted conversion
// RULE10: interrupt enable raises request every conversion end
// RULE11: flag unused as done when interrupts enabled
// RULE12: selected pin forced input, port writes ignored
// RULE13: port read of claimed pin returns zero
// RULE14: unselected pins stay normal general purpose
// RULE15: linear coding, upper reference full scale
// RULE16: software sets converter clock near 1 MHz
// RULE17: keeps running in wait, interrupt wakes
// RULE18: software powers down via channel select before wait
// RULE19: stop mode aborts conversion, converter inactive
// RULE20: after stop, first conversion period stabilises; code adds it only on resuming in continuous mode
// RULE21: flag reads zero with interrupts enabled; reset clears
// RULE22: result read or control write withdraws interrupt
// RULE23: five-bit channel select, codes 29/30 refs, ones off
// RULE24: three-bit divider 1,2,4,8,16; source bit, oscillator default
// RULE25: reset leaves idle, bits clear, no interrupt
// RULE26: power-off code blocks conversions and result updates
package sac_pkg;
  localparam logic [11:0] SAC_CTRL_OFS = 12'h000;
  localparam logic [11:0] SAC_RESULT_OFS = 12'h004;
  localparam logic [11:0] SAC_CLKCFG_OFS = 12'h008;
  localparam logic [11:0] SAC_PORTDATA_OFS = 12'h00c;
  localparam logic [11:0] SAC_PORTDIR_OFS = 12'h010;
  localparam logic [11:0] SAC_PORTIN_OFS = 12'h014;
  // control/status field positions
  localparam int SAC_CH_LSB = 0;
  localparam int SAC_CONT_BIT = 5;
  localparam int SAC_IEN_BIT = 6;
  localparam int SAC_DONE_BIT = 7;
  // clock config field positions
  localparam int SAC_SRC_BIT = 4;
  localparam int SAC_DIV_LSB = 5;
  localparam logic [4:0] SAC_CH_OFF = 5'h1f;
  localparam logic [4:0] SAC_CH_REFH = 5'h1d;
  localparam logic [4:0] SAC_CH_REFL = 5'h1e;
  localparam logic [4:0] SAC_CTRL_RST = 5'h1f;
  localparam logic [2:0] SAC_DIV_RST = 3'h0;
  localparam logic SAC_SRC_RST = 1'b0;
  localparam int SAC_CONV_CYCLES = 16;
  // settle ticks ahead of the first trial, sixteen ticks in all
  localparam logic [4:0] SAC_SETTLE_TICKS = 5'h06;
  localparam int SAC_RES_BITS = 8;
  localparam int SAC_NCH = 8;
  typedef enum logic [1:0] {SAC_IDLE, SAC_SETTLE, SAC_CONV, SAC_DONE} sac_state_t;
endpackage : sac_pkg

// ==== sac_clk_div.sv ====
// converter clock tick generator with source select and prescaler
`timescale 1ns/1ps
`default_nettype none
module sac_clk_div
  import sac_pkg::*;
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic busTick,
  input wire logic oscTick,
  input wire logic srcSel,
  input wire logic [2:0] divSel,
  output logic convTick
);
  logic [3:0] cnt_r;
  logic srcTick;
  logic [3:0] lim;
  always_comb
  begin
    srcTick = srcSel ? busTick : oscTick; // [RULE24]
    if (divSel[2])
      lim = 4'hf; // [RULE24]
    else
      lim = 4'((5'h1 << divSel[1:0]) - 5'h1);
  end
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r <= 4'h0;
      convTick <= 1'b0;
    end
    else
    begin
      convTick <= 1'b0;
      if (srcTick)
      begin
        if (cnt_r >= lim)
        begin
          cnt_r <= 4'h0;
          convTick <= 1'b1;
        end
        else
          cnt_r <= cnt_r + 4'h1;
      end
    end
  end
endmodule : sac_clk_div
`default_nettype wire

// ==== sac_sar.sv ====
// successive approximation engine driven by comparator input
`timescale 1ns/1ps
`default_nettype none
module sac_sar
  import sac_pkg::*;
#(
  parameter int BITS = SAC_RES_BITS
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic start,
  input wire logic abort,
  input wire logic step,
  input wire logic cmpHigh,
  output logic [BITS-1:0] trial,
  output logic busy,
  output logic finish
);
  logic [BITS-1:0] mask_r;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      trial <= '0;
      mask_r <= '0;
      busy <= 1'b0;
      finish <= 1'b0;
    end
    else
    begin
      finish <= 1'b0;
      if (abort)
        busy <= 1'b0;
      else if (start)
      begin
        mask_r <= {1'b1, {(BITS-1){1'b0}}};
        trial <= {1'b1, {(BITS-1){1'b0}}};
        busy <= 1'b1;
      end
      else if (busy && step)
      begin
        // keep bit when input at or above trial level, linear binary search [RULE15]
        if (!cmpHigh)
          trial <= trial & ~mask_r;
        mask_r <= mask_r >> 1;
        if (mask_r[0])
        begin
          busy <= 1'b0;
          finish <= 1'b1;
        end
        else
          trial <= (cmpHigh ? trial : (trial & ~mask_r)) | (mask_r >> 1);
      end
    end
  end
endmodule : sac_sar
`default_nettype wire

// ==== sac_conv_ctrl.sv ====
// converter control: apb registers, sequencing, mux select and port override
`timescale 1ns/1ps
`default_nettype none
module sac_conv_ctrl
  import sac_pkg::*;
#(
  parameter int NCH = SAC_NCH
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic busTick,
  input wire logic oscTick,
  input wire logic stopMode,
  input wire logic cmpHigh,
  output logic [4:0] muxSelect,
  output logic analogEnable,
  output logic [sac_pkg::SAC_RES_BITS-1:0] dacTrial,
  output logic convIrq,
  input wire logic [NCH-1:0] pinIn,
  output logic [NCH-1:0] pinOut,
  output logic [NCH-1:0] pinOe
);
  import sac_pkg::*;

  logic [4:0] chSel_r;
  logic contMode_r;
  logic irqEn_r;
  logic doneFlag_r;
  logic irqPend_r;
  logic clkSrc_r;
  logic [2:0] clkDiv_r;
  logic [SAC_RES_BITS-1:0] result_r;
  logic [NCH-1:0] portData_r;
  logic [NCH-1:0] portDir_r;
  logic [NCH-1:0] pinS1_r;
  logic [NCH-1:0] pinS2_r;
  logic [NCH-1:0] pinS3_r;
  logic [NCH-1:0] pinStable_r;
  logic stopS1_r;
  logic stopS2_r;
  logic stopS3_r;
  logic stopped_r;
  logic postStop_r;
  sac_state_t state_r;
  logic [4:0] cyc_r;

  logic busAcc;
  logic wrAcc;
  logic rdAcc;
  logic ctrlWr;
  logic resultRd;
  logic convTick;
  logic powerOff;
  logic sarStart;
  logic sarAbort;
  logic sarBusy;
  logic sarFinish;
  logic [SAC_RES_BITS-1:0] sarTrial;
  logic convEnd;
  logic [NCH-1:0] claimed;
  logic [NCH-1:0] portView;

  assign busAcc = psel && penable;
  assign wrAcc = busAcc && pwrite;
  assign rdAcc = busAcc && !pwrite;
  assign ctrlWr = wrAcc && (paddr == SAC_CTRL_OFS);
  assign resultRd = rdAcc && (paddr == SAC_RESULT_OFS);
  assign powerOff = (chSel_r == SAC_CH_OFF);

  // pins claimed by the converter channel select
  always_comb
  begin
    claimed = '0;
    if (chSel_r < 5'(NCH))
      claimed[chSel_r[2:0]] = 1'b1; // [RULE3] [RULE23]
  end
  assign portView = pinStable_r & ~claimed; // [RULE13] [RULE14]

  // pin input synchroniser, change accepted once stages two and three agree
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pinS1_r <= '0;
      pinS2_r <= '0;
      pinS3_r <= '0;
      pinStable_r <= '0;
    end
    else
    begin
      pinS1_r <= pinIn;
      pinS2_r <= pinS1_r;
      pinS3_r <= pinS2_r;
      pinStable_r <= (pinS2_r & pinS3_r) | (pinStable_r & (pinS2_r | pinS3_r));
    end
  end

  // stop request synchroniser
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      stopS1_r <= 1'b0;
      stopS2_r <= 1'b0;
      stopS3_r <= 1'b0;
      stopped_r <= 1'b0;
    end
    else
    begin
      stopS1_r <= stopMode;
      stopS2_r <= stopS1_r;
      stopS3_r <= stopS2_r;
      if (stopS2_r == stopS3_r)
        stopped_r <= stopS2_r;
    end
  end

  sac_clk_div u_div (
    .mclk(mclk),
    .rst(rst),
    .busTick(busTick),
    .oscTick(oscTick),
    .srcSel(clkSrc_r),
    .divSel(clkDiv_r),
    .convTick(convTick)
  );

  sac_sar #(.BITS(SAC_RES_BITS)) u_sar (
    .mclk(mclk),
    .rst(rst),
    .start(sarStart),
    .abort(sarAbort),
    .step(convTick && state_r == SAC_CONV),
    .cmpHigh(cmpHigh),
    .trial(sarTrial),
    .busy(sarBusy),
    .finish(sarFinish)
  );

  // control/status register fields
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      chSel_r <= SAC_CTRL_RST;
      contMode_r <= 1'b0; // [RULE25]
      irqEn_r <= 1'b0;
    end
    else if (ctrlWr)
    begin
      chSel_r <= pwdata[SAC_CH_LSB +: 5]; // [RULE23]
      contMode_r <= pwdata[SAC_CONT_BIT]; // [RULE6]
      irqEn_r <= pwdata[SAC_IEN_BIT];
    end
  end

  // clock config and port registers
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      clkSrc_r <= SAC_SRC_RST; // [RULE24]
      clkDiv_r <= SAC_DIV_RST;
      portData_r <= '0;
      portDir_r <= '0;
    end
    else if (wrAcc)
    begin
      if (paddr == SAC_CLKCFG_OFS)
      begin
        clkSrc_r <= pwdata[SAC_SRC_BIT];
        clkDiv_r <= pwdata[SAC_DIV_LSB +: 3];
      end
      if (paddr == SAC_PORTDATA_OFS)
        portData_r <= pwdata[NCH-1:0];
      if (paddr == SAC_PORTDIR_OFS)
        portDir_r <= pwdata[NCH-1:0];
    end
  end

  // conversion sequencer
  assign sarAbort = ctrlWr || stopped_r || powerOff; // [RULE1] [RULE19] [RULE26]
  assign sarStart = (state_r == SAC_SETTLE) && convTick && (cyc_r == 5'h0) && !sarAbort;
  assign convEnd = (state_r == SAC_DONE) && convTick && !sarAbort;

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      state_r <= SAC_IDLE; // [RULE25]
      cyc_r <= 5'h0;
      postStop_r <= 1'b0;
    end
    else
    begin
      if (stopped_r)
        postStop_r <= 1'b1;
      if (ctrlWr)
      begin
        state_r <= (pwdata[SAC_CH_LSB +: 5] == SAC_CH_OFF) ? SAC_IDLE : SAC_SETTLE; // [RULE1] [RULE26]
        cyc_r <= SAC_SETTLE_TICKS; // [RULE2]
      end
      else if (stopped_r || powerOff)
        state_r <= SAC_IDLE; // [RULE19] [RULE26]
      else
      begin
        case (state_r)
          SAC_IDLE:
          begin
            // leaving stop in continuous mode: resume, spending a whole conversion period settling
            if (postStop_r && contMode_r)
            begin
              state_r <= SAC_SETTLE; // [RULE20]
              cyc_r <= 5'(SAC_CONV_CYCLES) + SAC_SETTLE_TICKS;
              postStop_r <= 1'b0;
            end
          end
          SAC_SETTLE:
          begin
            if (convTick)
            begin
              if (cyc_r == 5'h0)
                state_r <= SAC_CONV;
              else
                cyc_r <= cyc_r - 5'h1; // [RULE20]
            end
          end
          SAC_CONV:
          begin
            if (sarFinish)
              state_r <= SAC_DONE; // [RULE2]
          end
          SAC_DONE:
          begin
            if (convTick)
            begin
              state_r <= contMode_r ? SAC_SETTLE : SAC_IDLE; // [RULE6] [RULE8]
              cyc_r <= SAC_SETTLE_TICKS; // [RULE2]
            end
          end
          default:
            state_r <= SAC_IDLE;
        endcase
      end
    end
  end

  // result register, overwritten every conversion
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      result_r <= '0;
    else if (convEnd)
      result_r <= sarTrial; // [RULE4] [RULE5]
  end

  // done flag and interrupt, set wins over clear
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      doneFlag_r <= 1'b0; // [RULE21]
      irqPend_r <= 1'b0;
    end
    else
    begin
      if (convEnd && !irqEn_r)
        doneFlag_r <= 1'b1; // [RULE7]
      else if (resultRd || irqEn_r)
        doneFlag_r <= 1'b0; // [RULE11]
      if (convEnd && irqEn_r)
        irqPend_r <= 1'b1; // [RULE10] [RULE17]
      else if (resultRd || ctrlWr || !irqEn_r)
        irqPend_r <= 1'b0; // [RULE22]
    end
  end

  // apb read data, ready with no wait state
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
      prdata <= '0;
    else if (psel && !penable && !pwrite)
    begin
      case (paddr)
        SAC_CTRL_OFS:
          prdata <= {24'h0, doneFlag_r && !irqEn_r, irqEn_r, contMode_r, chSel_r}; // [RULE21]
        SAC_RESULT_OFS:
          prdata <= {24'h0, result_r};
        SAC_CLKCFG_OFS:
          prdata <= {24'h0, clkDiv_r, clkSrc_r, 4'h0};
        SAC_PORTDATA_OFS:
          prdata <= 32'(portData_r);
        SAC_PORTDIR_OFS:
          prdata <= 32'(portDir_r);
        SAC_PORTIN_OFS:
          prdata <= 32'(portView); // [RULE13]
        default:
          prdata <= '0;
      endcase
    end
  end

  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= psel && !penable && !(paddr == SAC_CTRL_OFS || paddr == SAC_RESULT_OFS ||
        paddr == SAC_CLKCFG_OFS || paddr == SAC_PORTDATA_OFS || paddr == SAC_PORTDIR_OFS ||
        paddr == SAC_PORTIN_OFS);
    end
  end

  // analog side and pin drive
  assign dacTrial = sarTrial;
  always_ff @(posedge mclk or posedge rst)
  begin
    if (rst)
    begin
      muxSelect <= SAC_CH_OFF;
      analogEnable <= 1'b0;
      convIrq <= 1'b0;
      pinOut <= '0;
      pinOe <= '0;
    end
    else
    begin
      muxSelect <= chSel_r; // [RULE3]
      analogEnable <= !powerOff && !stopped_r; // [RULE19] [RULE26]
      convIrq <= irqPend_r; // [RULE10]
      pinOut <= portData_r & ~claimed; // [RULE12]
      pinOe <= portDir_r & ~claimed; // [RULE12] [RULE14]
    end
  end
endmodule : sac_conv_ctrl
`default_nettype wire

// ==== sac_conv_ctrl_checker.sv ====
// port-level checker for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sac_conv_ctrl_checker
  import sac_pkg::*;
#(
  parameter int NCH = SAC_NCH
)
(
  input wire logic mclk,
  input wire logic rst,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [11:0] paddr,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic stopMode,
  input wire logic [4:0] muxSelect,
  input wire logic analogEnable,
  input wire logic convIrq,
  input wire logic [NCH-1:0] pinOut,
  input wire logic [NCH-1:0] pinOe
);
  default clocking @(posedge mclk); endclocking
  default disable iff (rst);
  a_ready_setup:
    assert property (psel && !penable |=> pready) else $error("no ready after setup");
  a_ready_pulse:
    assert property (pready |=> !pready) else $error("ready held");
  a_refused_zero:
    assert property (pslverr && !pwrite |-> pready && prdata == 32'h0) else $error("bad refusal");
  a_claimed_pin:
    assert property (muxSelect < 5'h08 && $stable(muxSelect)
      |-> !pinOe[muxSelect[2:0]] && !pinOut[muxSelect[2:0]]) else $error("claimed pin driven");
  a_off_disabled:
    assert property (muxSelect == SAC_CH_OFF && $past(muxSelect) == SAC_CH_OFF
      |-> !analogEnable) else $error("off code but enabled");
  a_stop_inactive:
    assert property (stopMode [*6] |-> !analogEnable ##1 !$rose(convIrq))
      else $error("active in stop");
  a_irq_enabled:
    assert property ($rose(convIrq) |-> $past(analogEnable)) else $error("irq while off");
  a_write_clears:
    assert property (psel && penable && pwrite && paddr == SAC_CTRL_OFS |-> ##2 !convIrq)
      else $error("irq kept after write");
endmodule : sac_conv_ctrl_checker
bind sac_conv_ctrl sac_conv_ctrl_checker #(.NCH(NCH)) u_sac_conv_ctrl_checker (
  .mclk(mclk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
  .paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr),
  .stopMode(stopMode), .muxSelect(muxSelect), .analogEnable(analogEnable),
  .convIrq(convIrq), .pinOut(pinOut), .pinOe(pinOe));
`default_nettype wire

// ==== sac_afe_model.sv ====
// analog mux, comparator and pin pad model
`timescale 1ns/1ps
`default_nettype none
module sac_afe_model
  import sac_pkg::*;
(
  input wire logic [4:0] muxSelect,
  input wire logic analogEnable,
  input wire logic [SAC_RES_BITS-1:0] dacTrial,
  input wire logic [63:0] levels,
  input wire logic [7:0] extPins,
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  output logic cmpHigh,
  output logic [7:0] pinIn
);
  logic [7:0] vin;
  always_comb
  begin
    vin = 8'h00;
    if (muxSelect < 5'h08)
      vin = levels[muxSelect[2:0]*8 +: 8];
    if (muxSelect == SAC_CH_REFH)
      vin = 8'hff;
  end
  // disabled comparator follows no level
  assign cmpHigh = analogEnable ? (vin >= dacTrial) : ~dacTrial[0];
  assign pinIn = (pinOe & pinOut) | (~pinOe & extPins);
endmodule : sac_afe_model
`default_nettype wire

// ==== sac_conv_ctrl_tb.sv ====
// self-checking bench for the converter control block
`timescale 1ns/1ps
`default_nettype none
module sac_conv_ctrl_tb;
  import sac_pkg::*;
  logic mclk = 1'b0;
  logic rst = 1'b1;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic busTick = 1'b0;
  logic oscTick = 1'b0;
  logic stopMode = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [63:0] levels = 64'h0;
  logic [7:0] extPins = 8'h00;
  logic [31:0] prdata, rd, dir, dat, msk;
  logic [4:0] muxSelect;
  logic [7:0] dacTrial, pinIn, pinOut, pinOe;
  logic pready, pslverr, cmpHigh, analogEnable, convIrq, err;
  int bad_count = 0;
  int num_checks = 0;
  int cycles = 0;
  int n;
  int ch;
  sac_conv_ctrl u_sac_conv_ctrl (.mclk(mclk), .rst(rst), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .busTick(busTick), .oscTick(oscTick), .stopMode(stopMode),
    .cmpHigh(cmpHigh), .muxSelect(muxSelect), .analogEnable(analogEnable),
    .dacTrial(dacTrial), .convIrq(convIrq), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe));
  sac_afe_model u_sac_afe_model (.muxSelect(muxSelect), .analogEnable(analogEnable),
    .dacTrial(dacTrial), .levels(levels), .extPins(extPins), .pinOut(pinOut),
    .pinOe(pinOe), .cmpHigh(cmpHigh), .pinIn(pinIn));
  initial
  begin
    forever #2.5 mclk = ~mclk;
  end
  always @(posedge mclk)
  begin
    busTick <= 1'($urandom % 2);
    oscTick <= ~oscTick;
    cycles <= cycles + 1;
    if (cycles == 90000)
    begin
      bad_count++;
      end_sim();
    end
  end
  task end_sim;
    $display("checks %0d mismatches %0d", num_checks, bad_count);
    if (bad_count == 0 && num_checks > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask : end_sim
  task chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    num_checks++;
    if (got !== exp)
    begin
      $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      bad_count++;
    end
  endtask : chk
  task apb(input logic w, input logic [11:0] a, input logic [31:0] d);
    @(posedge mclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    penable <= 1'b0;
    @(posedge mclk);
    penable <= 1'b1;
    @(posedge mclk);
    while (pready !== 1'b1)
      @(posedge mclk);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task waitDone(input logic irq);
    n = 0;
    rd = 32'h0;
    while (n < 3000 && (irq ? convIrq !== 1'b1 : rd[SAC_DONE_BIT] !== 1'b1))
    begin
      n++;
      if (irq)
        @(posedge mclk);
      else
        apb(1'b0, SAC_CTRL_OFS, 32'h0);
    end
    chk("conversion end", 32'h1, {31'h0, n < 3000});
  endtask : waitDone
  function automatic logic [7:0] expVal(input int c);
    if (c < 8)
      return levels[c*8 +: 8];
    return (c == int'(SAC_CH_REFH)) ? 8'hff : 8'h00;
  endfunction : expVal
  initial
  begin
    n = $urandom(75);
    repeat (4) @(posedge mclk);
    rst <= 1'b0;
    levels <= {$urandom, $urandom};
    @(negedge mclk);
    chk("irq idle", 32'h0, {31'h0, convIrq});
    apb(1'b0, SAC_CTRL_OFS, 32'h0);
    chk("ctrl reset", {27'h0, SAC_CTRL_RST}, rd);
    apb(1'b0, SAC_CLKCFG_OFS, 32'h0);
    chk("clock reset", 32'h0, rd);
    apb(1'b0, 12'h040, 32'h0);
    chk("unmapped", 32'h1, {31'h0, err});
    dat = {24'h0, 3'($urandom % 8), 1'b1, 4'h0};
    apb(1'b1, SAC_CLKCFG_OFS, dat);
    apb(1'b0, SAC_CLKCFG_OFS, 32'h0);
    chk("clock cfg", dat, rd);
    for (int i = 0; i < 10; i++)
    begin
      ch = (i < 8) ? i : i + 21;
      apb(1'b1, SAC_CTRL_OFS, 32'(ch));
      waitDone(1'b0);
      apb(1'b0, SAC_RESULT_OFS, 32'h0);
      chk("result", {24'h0, expVal(ch)}, rd);
      repeat (300) @(posedge mclk);
      apb(1'b0, SAC_CTRL_OFS, 32'h0);
      chk("single idle", 32'(ch), rd);
    end
    apb(1'b1, SAC_CTRL_OFS, 32'h0);
    repeat (5) @(posedge mclk);
    apb(1'b1, SAC_CTRL_OFS, 32'h1);
    waitDone(1'b0);
    apb(1'b0, SAC_RESULT_OFS, 32'h0);
    chk("restart", {24'h0, expVal(1)}, rd);
    apb(1'b1, SAC_CLKCFG_OFS, 32'h0);
    apb(1'b1, SAC_CTRL_OFS, 32'h42);
    waitDone(1'b1);
    chk("conv time", 32'h1, {31'h0, n >= 2 * SAC_CONV_CYCLES && n <= 2 * SAC_CONV_CYCLES + 4});
    apb(1'b0, SAC_CTRL_OFS, 32'h0);
    chk("flag with irq", 32'h42, rd);
    apb(1'b0, SAC_RESULT_OFS, 32'h0);
    chk("irq result", {24'h0, expVal(2)}, rd);
    repeat (2) @(posedge mclk);
    chk("irq withdrawn", 32'h0, {31'h0, convIrq});
    apb(1'b1, SAC_CTRL_OFS, 32'h5f);
    repeat (500) @(posedge mclk);
    chk("off no irq", 32'h0, {31'h0, convIrq});
    apb(1'b1, SAC_CTRL_OFS, 32'h23);
    waitDone(1'b0);
    levels[31:24] <= ~levels[31:24];
    repeat (2)
    begin
      apb(1'b0, SAC_RESULT_OFS, 32'h0);
      waitDone(1'b0);
    end
    apb(1'b0, SAC_RESULT_OFS, 32'h0);
    chk("continuous", {24'h0, expVal(3)}, rd);
    stopMode <= 1'b1;
    repeat (20) @(posedge mclk);
    chk("stop", 32'h0, {31'h0, analogEnable});
    apb(1'b0, SAC_RESULT_OFS, 32'h0);
    repeat (500) @(posedge mclk);
    apb(1'b0, SAC_CTRL_OFS, 32'h0);
    chk("stop no done", 32'h23, rd);
    stopMode <= 1'b0;
    waitDone(1'b0);
    repeat (4)
    begin
      dir = $urandom;
      dat = $urandom;
      extPins <= 8'($urandom);
      ch = $urandom % 8;
      msk = ~(32'h1 << ch) & 32'hff;
      apb(1'b1, SAC_CTRL_OFS, 32'(ch));
      apb(1'b1, SAC_PORTDIR_OFS, dir & 32'hff);
      apb(1'b1, SAC_PORTDATA_OFS, dat & 32'hff);
      repeat (6) @(posedge mclk);
      chk("pin enable", dir & msk, {24'h0, pinOe});
      chk("pin drive", dat & dir & msk, {24'h0, pinOut & pinOe});
      apb(1'b0, SAC_PORTIN_OFS, 32'h0);
      chk("pin read", ((dir & dat) | (~dir & 32'(extPins))) & msk, rd);
    end
    end_sim();
  end
endmodule : sac_conv_ctrl_tb
`default_nettype wire
